// ===== src/sclk_ctrl.sv
// clock divider, idle wake-up and priority control for a small microcontroller
// assumes external pins already synchronised upstream; core logic on sys_clk_i
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module sclk_ctrl
  import sclk_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // events from the core
  input  wire logic        idle_i,
  input  wire logic        ms_tick_i,
  input  wire logic        ms_irq_en_i,
  input  wire logic        ms_ovf_i,
  input  wire logic        aux_src_i,
  input  wire logic        wdt_event_i,
  input  wire logic        wdt_reset_en_i,
  input  wire logic        ext0_irq_i,
  input  wire logic        ext1_irq_i,
  input  wire logic [4:0]  irq_req_i,
  // outputs
  output logic             clk_en_o,
  output logic             divided_o,
  output logic             wake_o,
  output logic             aux_irq_o,
  output logic             wdt_irq_o,
  output logic [2:0]       grant_idx_o,
  output logic             grant_valid_o,
  output logic             grant_high_o,
  output logic             irq_o
);
  sclk_bus_t   bus;
  sclk_irq_t   irq;
  logic [4:0]  prio_q, prio_d;
  logic [2:0]  wake_en_q, wake_en_d;
  logic [2:0]  divsel_q, divsel_d;
  logic        aux_en_q, aux_en_d;
  logic        aux_flg_q, aux_flg_d;
  logic        wdt_flg_q, wdt_flg_d;
  logic [2:0]  ist_q, ist_d;
  logic [2:0]  imask_q, imask_d;
  logic [7:0]  rdata_q, rdata_d;
  sclk_state_t st_q, st_d;
  logic        wake_pend_q, wake_pend_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic        div_en_q, div_en_d;
  logic [DIV_W-1:0] div_last;
  logic        wake;
  logic        div_wr;
  logic        divided;
  logic [1:0]  dm_status;
  logic [4:0]  hi_req;
  logic [4:0]  lo_req;
  logic [7:0]  wv;

  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign irq.req = irq_req_i;
  assign wv = bus.wdata;
  assign div_wr = bus.wr && (bus.addr == SCLK_DIV_ADDR);

  always_comb begin
    case (divsel_q)
      3'h0: div_last = DIV_W'(1);
      3'h1: div_last = DIV_W'(3);
      3'h2: div_last = DIV_W'(7);
      3'h3: div_last = DIV_W'(15);
      3'h4: div_last = DIV_W'(31);
      3'h5: div_last = DIV_W'(1023);
      3'h6: div_last = DIV_W'(2047);
      default: div_last = DIV_W'(4095);
    endcase
  end

  assign wake = idle_i && ((aux_en_q && aux_flg_q)
              || (wake_en_q[SCLK_WAKE_WDT] && wdt_irq_o)
              || (wake_en_q[SCLK_WAKE_EX1] && ext1_irq_i)
              || (wake_en_q[SCLK_WAKE_EX0] && ext0_irq_i));

  // divider state machine
  always_comb begin
    st_d = st_q;
    wake_pend_d = wake_pend_q;
    case (st_q)
      SCLK_ST_NORM: ;
      SCLK_ST_IMM:   if (wake) st_d = SCLK_ST_NORM;
      // start on next tick even masked
      SCLK_ST_DWAIT: if (ms_tick_i) st_d = SCLK_ST_DDIV;
      SCLK_ST_DDIV: begin
        // masked: overflow after wake ends it
        if (wake) wake_pend_d = 1'b1;
        if (ms_irq_en_i && ms_tick_i) begin
          st_d = SCLK_ST_NORM;
        end else if (!ms_irq_en_i && wake_pend_q && ms_ovf_i) begin
          st_d = SCLK_ST_NORM;
        end
      end
      SCLK_ST_MAN: ;
      default: st_d = SCLK_ST_NORM;
    endcase
    if (div_wr) begin
      wake_pend_d = 1'b0;
      case (sclk_dmode_t'(wv[SCLK_DMODE_LSB +: 2]))
        SCLK_DM_IMMED:  st_d = SCLK_ST_IMM;
        SCLK_DM_DELAY:  st_d = SCLK_ST_DWAIT;
        SCLK_DM_MANUAL: st_d = SCLK_ST_MAN;
        default:        st_d = SCLK_ST_NORM;
      endcase
    end
    if (st_d == SCLK_ST_NORM) wake_pend_d = 1'b0;
  end

  assign divided = (st_q == SCLK_ST_IMM) || (st_q == SCLK_ST_DDIV) || (st_q == SCLK_ST_MAN);

  always_comb begin
    case (st_q)
      SCLK_ST_IMM:   dm_status = SCLK_DM_IMMED;
      SCLK_ST_DWAIT: dm_status = SCLK_DM_DELAY;
      SCLK_ST_DDIV:  dm_status = SCLK_DM_DELAY;
      SCLK_ST_MAN:   dm_status = SCLK_DM_MANUAL;
      default:       dm_status = SCLK_DM_NORMAL;
    endcase
  end

  // clock enable divider
  always_comb begin
    cnt_d = cnt_q;
    div_en_d = 1'b1;
    if (divided) begin
      if (cnt_q >= div_last) begin
        cnt_d = '0;
        div_en_d = 1'b1;
      end else begin
        cnt_d = cnt_q + DIV_W'(1);
        div_en_d = 1'b0;
      end
    end else begin
      cnt_d = '0;
    end
  end

  // register writes and flags
  always_comb begin
    prio_d = prio_q;
    wake_en_d = wake_en_q;
    divsel_d = divsel_q;
    aux_en_d = aux_en_q;
    aux_flg_d = aux_flg_q;
    wdt_flg_d = wdt_flg_q;
    imask_d = imask_q;
    ist_d = ist_q;
    if (bus.wr) begin
      case (bus.addr)
        SCLK_PRIO_ADDR: prio_d = wv[SCLK_PRIO_W-1:0];
        SCLK_WAKE_ADDR: wake_en_d = wv[2:0];
        SCLK_DIV_ADDR:  divsel_d = wv[2:0];
        SCLK_AUX_ADDR: begin
          aux_en_d = wv[SCLK_AUX_EN_BIT];
          aux_flg_d = wv[SCLK_AUX_FLG_BIT];
          wdt_flg_d = wv[SCLK_WDT_FLG_BIT];
        end
        SCLK_ISTAT_ADDR: ist_d = ist_q & ~wv[2:0];
        SCLK_IMASK_ADDR: imask_d = wv[2:0];
        default: ;
      endcase
    end
    if (aux_src_i) aux_flg_d = 1'b1;
    if (wdt_event_i && !wdt_reset_en_i) wdt_flg_d = 1'b1;
    if (wake) ist_d[SCLK_EV_WAKE] = 1'b1;
    if (!divided && st_d inside {SCLK_ST_IMM, SCLK_ST_DDIV, SCLK_ST_MAN}) begin
      ist_d[SCLK_EV_DIVON] = 1'b1;
    end
    if (divided && st_d == SCLK_ST_NORM) ist_d[SCLK_EV_DIVOFF] = 1'b1;
  end

  // read data, one cycle later
  always_comb begin
    rdata_d = SCLK_ZERO8;
    if (bus.rd) begin
      case (bus.addr)
        SCLK_PRIO_ADDR:  rdata_d = SCLK_PRIO_RST | {3'h0, prio_q};
        SCLK_WAKE_ADDR:  rdata_d = {5'h0, wake_en_q};
        SCLK_DIV_ADDR:   rdata_d = {2'h0, dm_status, 1'b0, divsel_q};
        SCLK_AUX_ADDR:   rdata_d = SCLK_AUX_RST | {2'h0, aux_en_q, aux_flg_q, wdt_flg_q, 3'h0};
        SCLK_ISTAT_ADDR: rdata_d = {5'h0, ist_q};
        SCLK_IMASK_ADDR: rdata_d = {5'h0, imask_q};
        default:         rdata_d = SCLK_ZERO8;
      endcase
    end
  end

  assign hi_req = irq.req & prio_q;
  assign lo_req = irq.req & ~prio_q;

  // high level first, bit 0 first within level
  always_comb begin
    grant_idx_o = 3'h0;
    grant_valid_o = 1'b0;
    grant_high_o = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      if (lo_req[i]) begin
        grant_idx_o = 3'(i);
        grant_valid_o = 1'b1;
      end
    end
    for (int i = 4; i >= 0; i--) begin
      if (hi_req[i]) begin
        grant_idx_o = 3'(i);
        grant_valid_o = 1'b1;
        grant_high_o = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_q      <= '0;
      wake_en_q   <= '0;
      divsel_q    <= '0;
      aux_en_q    <= 1'b0;
      aux_flg_q   <= 1'b0;
      wdt_flg_q   <= 1'b0;
      ist_q       <= '0;
      imask_q     <= '0;
      rdata_q     <= '0;
      st_q        <= SCLK_ST_NORM;
      wake_pend_q <= 1'b0;
      cnt_q       <= '0;
      div_en_q    <= 1'b1;
    end else begin
      prio_q      <= prio_d;
      wake_en_q   <= wake_en_d;
      divsel_q    <= divsel_d;
      aux_en_q    <= aux_en_d;
      aux_flg_q   <= aux_flg_d;
      wdt_flg_q   <= wdt_flg_d;
      ist_q       <= ist_d;
      imask_q     <= imask_d;
      rdata_q     <= rdata_d;
      st_q        <= st_d;
      wake_pend_q <= wake_pend_d;
      cnt_q       <= cnt_d;
      div_en_q    <= div_en_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign clk_en_o    = div_en_q;
  assign divided_o   = divided;
  assign wake_o      = wake;
  assign aux_irq_o   = aux_en_q && aux_flg_q;
  assign wdt_irq_o   = wdt_flg_q;
  assign irq_o       = |(ist_q & imask_q);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_imm_write;
    div_wr && wv[5:4] == 2'h1;
  endsequence

  a_aux_gate_req: assert property (
    aux_irq_o == (aux_en_q && aux_flg_q)) else $error("aux request not gated by enable");
  a_aux_sw_set: assert property (
    bus.wr && bus.addr == SCLK_AUX_ADDR && wv[5] && wv[4] |=> aux_irq_o)
    else $error("software aux set did not raise request");
  a_aux_flag_sticky: assert property (
    aux_flg_q && !(bus.wr && bus.addr == SCLK_AUX_ADDR) |=> aux_flg_q)
    else $error("aux flag dropped without software clear");
  a_wdt_flag_sticky: assert property (
    wdt_flg_q && !(bus.wr && bus.addr == SCLK_AUX_ADDR) |=> wdt_flg_q)
    else $error("watchdog flag dropped without software clear");
  a_imm_start: assert property (
    s_imm_write |=> divided_o && dm_status == 2'h1) else $error("immediate mode did not start");
  a_imm_wake_exit: assert property (
    st_q == SCLK_ST_IMM && wake && !div_wr |=> !divided_o) else $error("wake did not end divide");
  a_manual_hold: assert property (
    st_q == SCLK_ST_MAN && !div_wr |=> st_q == SCLK_ST_MAN) else $error("manual mode left");
  a_norm_write: assert property (
    div_wr && wv[5:4] == 2'h0 |=> !divided_o ##1 clk_en_o) else $error("normal write failed");
  a_delay_tick: assert property (
    st_q == SCLK_ST_DWAIT && ms_tick_i && !div_wr |=> st_q == SCLK_ST_DDIV)
    else $error("delay mode missed tick");
  a_prio_high: assert property (
    |hi_req |-> grant_high_o && hi_req[grant_idx_o]) else $error("high priority not taken");
  a_wake_enable: assert property (
    wake |-> (aux_en_q && aux_flg_q) || (|(wake_en_q & {wdt_irq_o, ext1_irq_i, ext0_irq_i})))
    else $error("wake without enabled source");
endmodule

`default_nettype wire

// ===== src/sclk_pkg.sv
// package for the system clock divider, wake-up and interrupt priority block
// assumes a plain register port with one-cycle read latency
package sclk_pkg;
  // register offsets
  localparam logic [7:0] SCLK_PRIO_ADDR  = 8'hB8;
  localparam logic [7:0] SCLK_WAKE_ADDR  = 8'hC6;
  localparam logic [7:0] SCLK_DIV_ADDR   = 8'hC7;
  localparam logic [7:0] SCLK_AUX_ADDR   = 8'hD8;
  localparam logic [7:0] SCLK_ISTAT_ADDR = 8'hF0;
  localparam logic [7:0] SCLK_IMASK_ADDR = 8'hF1;
  // reset values and fixed bits
  localparam logic [7:0] SCLK_PRIO_RST   = 8'h80;
  localparam logic [7:0] SCLK_AUX_RST    = 8'h40;
  localparam logic [7:0] SCLK_ZERO8      = 8'h00;
  // field positions
  localparam int SCLK_PRIO_W      = 5;
  localparam int SCLK_DMODE_LSB   = 4;
  localparam int SCLK_AUX_EN_BIT  = 5;
  localparam int SCLK_AUX_FLG_BIT = 4;
  localparam int SCLK_WDT_FLG_BIT = 3;
  localparam int SCLK_WAKE_WDT    = 2;
  localparam int SCLK_WAKE_EX1    = 1;
  localparam int SCLK_WAKE_EX0    = 0;
  // interrupt status bits
  localparam int SCLK_EV_W        = 3;
  localparam int SCLK_EV_WAKE     = 0;
  localparam int SCLK_EV_DIVON    = 1;
  localparam int SCLK_EV_DIVOFF   = 2;

  typedef enum logic [1:0] {
    SCLK_DM_NORMAL = 2'h0,
    SCLK_DM_IMMED  = 2'h1,
    SCLK_DM_DELAY  = 2'h2,
    SCLK_DM_MANUAL = 2'h3
  } sclk_dmode_t;

  // one-hot divider states
  typedef enum logic [4:0] {
    SCLK_ST_NORM  = 5'h01,
    SCLK_ST_IMM   = 5'h02,
    SCLK_ST_DWAIT = 5'h04,
    SCLK_ST_DDIV  = 5'h08,
    SCLK_ST_MAN   = 5'h10
  } sclk_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sclk_bus_t;

  // five classic sources, bit 4 serial 0 down to bit 0 external 0
  typedef struct packed {
    logic [4:0] req;
  } sclk_irq_t;
endpackage

// ===== verif/tb.sv
// self-checking bench for the clock divider, wake-up and priority block
// assumes one 100 MHz clock and the plain register port of the package
`timescale 1ns/1ps
`default_nettype none
module tb import sclk_pkg::*;;
  logic        sys_clk_i, rst_i, wr, rd, idle, tick, ms_en, ovf, aux, wdt, wdt_rst;
  logic        ext0, ext1, clk_en, divd, wake, aux_irq, wdt_irq, gvalid, ghigh, irq;
  logic [7:0]  addr, wdata, rdata;
  logic [4:0]  req;
  logic [2:0]  gidx;
  logic [15:0] scr;
  int          fails, n_tests;
  int          cyc = 0;

  sclk_ctrl dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .idle_i(idle), .ms_tick_i(tick),
    .ms_irq_en_i(ms_en), .ms_ovf_i(ovf), .aux_src_i(aux), .wdt_event_i(wdt),
    .wdt_reset_en_i(wdt_rst), .ext0_irq_i(ext0), .ext1_irq_i(ext1), .irq_req_i(req),
    .clk_en_o(clk_en), .divided_o(divd), .wake_o(wake), .aux_irq_o(aux_irq),
    .wdt_irq_o(wdt_irq), .grant_idx_o(gidx), .grant_valid_o(gvalid), .grant_high_o(ghigh),
    .irq_o(irq)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
    #1;
    chk(nm, {8'h00, exp}, {8'h00, rdata});
  endtask

  // one-cycle pulse: 0 tick, 1 overflow, 2 aux source, 3 watchdog
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    case (k)
      0: tick <= 1'b1;
      1: ovf <= 1'b1;
      2: aux <= 1'b1;
      default: wdt <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    {tick, ovf, aux, wdt} <= 4'h0;
    #1;
  endtask

  task automatic cnt(input int n, output logic [15:0] c);
    c = 16'h0000;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      c = c + {15'h0000, clk_en};
    end
  endtask

  task automatic t_reset();
    wr_reg(8'h55, 8'hFF);
    rd_reg(8'h55, 8'h00, "unmapped");
    rd_reg(SCLK_PRIO_ADDR, SCLK_PRIO_RST, "prio reset");
    rd_reg(SCLK_WAKE_ADDR, 8'h00, "wake reset");
    rd_reg(SCLK_DIV_ADDR, 8'h00, "div reset");
    rd_reg(SCLK_AUX_ADDR, SCLK_AUX_RST, "aux reset");
    $display("test reset done");
  endtask

  task automatic t_prio();
    req <= 5'h15;
    wr_reg(SCLK_PRIO_ADDR, 8'h00);
    chk("grant natural", 16'h0010, {11'h0, gvalid, ghigh, gidx});
    wr_reg(SCLK_PRIO_ADDR, 8'h10);
    chk("grant serial", 16'h001C, {11'h0, gvalid, ghigh, gidx});
    wr_reg(SCLK_PRIO_ADDR, 8'h14);
    chk("grant high", 16'h001A, {11'h0, gvalid, ghigh, gidx});
    rd_reg(SCLK_PRIO_ADDR, 8'h94, "prio");
    $display("test prio done");
  endtask

  task automatic t_wake();
    wr_reg(SCLK_DIV_ADDR, 8'h10);
    chk("divided", 16'h1, {15'h0, divd});
    rd_reg(SCLK_DIV_ADDR, 8'h10, "status");
    idle <= 1'b1;
    ext0 <= 1'b1;
    cnt(2, scr);
    chk("no wake", 16'h0, {15'h0, wake});
    chk("divided", 16'h1, {15'h0, divd});
    wr_reg(SCLK_WAKE_ADDR, 8'h01);
    chk("wake ext0", 16'h1, {15'h0, wake});
    cnt(1, scr);
    chk("undivided", 16'h0, {15'h0, divd});
    rd_reg(SCLK_DIV_ADDR, 8'h00, "status");
    {ext0, ext1} <= 2'h1;
    wr_reg(SCLK_WAKE_ADDR, 8'h02);
    chk("wake ext1", 16'h1, {15'h0, wake});
    $display("test wake done");
  endtask

  task automatic t_man();
    logic [15:0] c;
    {ext0, ext1} <= 2'h2;
    wr_reg(SCLK_WAKE_ADDR, 8'h01);
    wr_reg(SCLK_DIV_ADDR, 8'h30);
    cnt(4096, c);
    for (int i = 0; i < 8; i++) begin
      wr_reg(SCLK_DIV_ADDR, 8'h30 | 8'(i));
      cnt(4096, c);
      chk("enables", 16'(4096 / (i < 5 ? (2 << i) : (1024 << (i - 5)))), c);
    end
    chk("manual held", 16'h1, {15'h0, divd & wake});
    rd_reg(SCLK_DIV_ADDR, 8'h37, "status");
    {idle, ext0} <= 2'h0;
    wr_reg(SCLK_DIV_ADDR, 8'h00);
    cnt(32, c);
    chk("undivided", 16'd32, c);
    $display("test manual done");
  endtask

  task automatic t_delay();
    ms_en <= 1'b1;
    wr_reg(SCLK_DIV_ADDR, 8'h20);
    chk("waiting", 16'h0, {15'h0, divd});
    rd_reg(SCLK_DIV_ADDR, 8'h20, "status");
    pulse(0);
    chk("divided", 16'h1, {15'h0, divd});
    pulse(0);
    chk("ended", 16'h0, {15'h0, divd});
    ms_en <= 1'b0;
    wr_reg(SCLK_DIV_ADDR, 8'h20);
    pulse(0);
    pulse(1);
    chk("masked held", 16'h1, {15'h0, divd});
    {idle, ext0} <= 2'h3;
    cnt(2, scr);
    {idle, ext0} <= 2'h0;
    pulse(1);
    chk("masked ended", 16'h0, {15'h0, divd});
    $display("test delay done");
  endtask

  task automatic t_aux();
    wr_reg(SCLK_AUX_ADDR, 8'h30);
    chk("aux soft", 16'h1, {15'h0, aux_irq});
    rd_reg(SCLK_AUX_ADDR, 8'h70, "aux");
    wr_reg(SCLK_AUX_ADDR, 8'h20);
    chk("aux clear", 16'h0, {15'h0, aux_irq});
    wr_reg(SCLK_AUX_ADDR, 8'h00);
    pulse(2);
    chk("aux gated", 16'h0, {15'h0, aux_irq});
    rd_reg(SCLK_AUX_ADDR, 8'h50, "aux");
    wr_reg(SCLK_WAKE_ADDR, 8'h00);
    idle <= 1'b1;
    wr_reg(SCLK_AUX_ADDR, 8'h30);
    chk("aux wake", 16'h1, {15'h0, wake});
    wr_reg(SCLK_AUX_ADDR, 8'h00);
    chk("aux sleep", 16'h0, {15'h0, wake});
    $display("test aux done");
  endtask

  task automatic t_wdt();
    pulse(3);
    chk("wdt flag", 16'h1, {15'h0, wdt_irq});
    rd_reg(SCLK_AUX_ADDR, 8'h48, "aux");
    wr_reg(SCLK_WAKE_ADDR, 8'h04);
    chk("wdt wake", 16'h1, {15'h0, wake});
    wr_reg(SCLK_AUX_ADDR, 8'h40);
    chk("wdt clear", 16'h0, {15'h0, wdt_irq});
    wdt_rst <= 1'b1;
    pulse(3);
    chk("wdt reset", 16'h0, {15'h0, wdt_irq});
    idle <= 1'b0;
    $display("test watchdog done");
  endtask

  task automatic t_irq();
    wr_reg(SCLK_ISTAT_ADDR, 8'hFF);
    wr_reg(SCLK_IMASK_ADDR, 8'h00);
    wr_reg(SCLK_DIV_ADDR, 8'h30);
    chk("irq masked", 16'h0, {15'h0, irq});
    rd_reg(SCLK_ISTAT_ADDR, 8'h02, "istat");
    wr_reg(SCLK_IMASK_ADDR, 8'h02);
    chk("irq", 16'h1, {15'h0, irq});
    wr_reg(SCLK_ISTAT_ADDR, 8'h02);
    chk("irq cleared", 16'h0, {15'h0, irq});
    wr_reg(SCLK_DIV_ADDR, 8'h00);
    rd_reg(SCLK_ISTAT_ADDR, 8'h04, "istat");
    rd_reg(SCLK_IMASK_ADDR, 8'h02, "imask");
    $display("test irq done");
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // run length cut-off
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    rst_i = 1'b1;
    {wr, rd, idle, tick, ms_en, ovf, aux, wdt, wdt_rst, ext0, ext1} = '0;
    addr    = 8'h00;
    wdata   = 8'h00;
    req     = 5'h00;
    fails   = 0;
    n_tests = 0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_prio();
    t_wake();
    t_man();
    t_delay();
    t_aux();
    t_wdt();
    t_irq();
    test_done();
  end
endmodule
`default_nettype wire
